// ==== rtl/fsc_fail_detect.v ====
// Serious-failure detector counting switching cycles with overcurrent in both phases.
`default_nettype none
`include "fsc_regs.vh"
module fsc_fail_detect (
  input wire pclk,
  input wire presetn,
  input wire clear,
  input wire overcurrent,
  input wire phase_on,
  input wire cycle_end,
  output reg fail_ff
);
  reg seen_on_ff;
  reg seen_off_ff;
  reg [1:0] run_ff;
  wire both;

  // Counts the cycle that is ending, including this cycle's sample.
  assign both = (seen_on_ff | (overcurrent & phase_on)) &
                (seen_off_ff | (overcurrent & ~phase_on));

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seen_on_ff <= 1'b0;
      seen_off_ff <= 1'b0;
      run_ff <= 2'h0;
      fail_ff <= 1'b0;
    end
    else if (clear)
    begin
      seen_on_ff <= 1'b0;
      seen_off_ff <= 1'b0;
      run_ff <= 2'h0;
      fail_ff <= 1'b0;
    end
    else if (cycle_end)
    begin
      seen_on_ff <= 1'b0;
      seen_off_ff <= 1'b0;
      if (!both)
      begin
        run_ff <= 2'h0;
      end
      else if (run_ff == `FSC_SFAIL_CYCLES - 2'h1)
      begin
        fail_ff <= 1'b1;
      end
      else
      begin
        run_ff <= run_ff + 2'h1;
      end
    end
    else
    begin
      if (overcurrent & phase_on)
      begin
        seen_on_ff <= 1'b1;
      end
      if (overcurrent & ~phase_on)
      begin
        seen_off_ff <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/fsc_hiccup_timer.v ====
// Interval timer that spaces hiccup restart attempts.
`default_nettype none
module fsc_hiccup_timer #(
  parameter [31:0] CYCLES = 32'h05F5E100
) (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire abort,
  output reg busy_ff,
  output reg done_ff
);
  reg [31:0] cnt_ff;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= 32'h00000000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (abort)
      begin
        busy_ff <= 1'b0;
        cnt_ff <= 32'h00000000;
      end
      else if (start)
      begin
        busy_ff <= 1'b1;
        cnt_ff <= 32'h00000001;
      end
      else if (busy_ff)
      begin
        if (cnt_ff >= CYCLES)
        begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
        else
        begin
          cnt_ff <= cnt_ff + 32'h00000001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/fsc_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the fault signalling block.
`ifndef FSC_REGS_VH
`define FSC_REGS_VH

`define FSC_OFF_CTRL 8'h00
`define FSC_OFF_STATUS 8'h04
`define FSC_OFF_MASK 8'h08
`define FSC_OFF_PINS 8'h0C

`define FSC_CTRL_HICCUP 0
`define FSC_CTRL_FORCE 1
`define FSC_CTRL_RST 2'h1

`define FSC_ST_WIDTH 6
`define FSC_ST_FAULT 0
`define FSC_ST_WARN 1
`define FSC_ST_SFAIL 2
`define FSC_ST_LINE 3
`define FSC_ST_RESTART 4
`define FSC_ST_CLEARED 5
`define FSC_STATUS_RST 6'h00
`define FSC_MASK_RST 6'h00

`define FSC_PIN_LINE 0
`define FSC_PIN_DIR 1
`define FSC_PIN_EN 2
`define FSC_PIN_CONV 3
`define FSC_PIN_LATCH 4
`define FSC_PIN_WAIT 5
`define FSC_PIN_SFAIL 6

`define FSC_CLK_MHZ 200
`define FSC_HICCUP_MS 500
`define FSC_HICCUP_CYCLES (`FSC_HICCUP_MS * 1000 * `FSC_CLK_MHZ)
`define FSC_SFAIL_CYCLES 2'h3

`endif

// ==== rtl/fsc_top.v ====
// Fault and status signalling top: APB registers, shared fault line, hiccup and latch-off.
`default_nettype none
`include "fsc_regs.vh"
module fsc_top #(
  parameter [31:0] HICCUP_CYCLES = `FSC_HICCUP_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  input wire device_enable,
  input wire converter_enable,
  input wire direction_select,
  input wire fault_detect,
  input wire warning_detect,
  input wire second_level_overcurrent,
  input wire negative_overcurrent,
  input wire phase_on,
  input wire cycle_end,
  input wire [5:0] pwm_in,
  input wire driver_enable_req,
  input wire shared_fault_line_in,
  output reg shared_fault_line_out,
  output reg shared_fault_line_oe,
  input wire status_change_flag_in,
  output reg status_change_flag_out,
  output reg status_change_flag_oe,
  input wire serious_failure_flag_in,
  output reg serious_failure_flag_out,
  output wire serious_failure_flag_oe,
  output reg [5:0] pwm_out,
  output reg driver_enable_out,
  output reg boost_mode,
  output reg soft_start_restart
);
  localparam [2:0] ST_SHUT = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RUN = 3'h2;
  localparam [2:0] ST_WAIT = 3'h3;
  localparam [2:0] ST_LATCH = 3'h4;

  reg [1:0] ctrl_ff;
  reg [5:0] status_ff;
  reg [5:0] mask_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg restart_req;
  reg timer_start;
  reg fault_prev_ff;
  reg warn_prev_ff;
  reg line_prev_ff;
  reg sfail_prev_ff;
  reg [5:0] nxt_status;
  reg [5:0] hw_set;
  reg [5:0] rd_clear;
  reg [31:0] rd_mux;
  reg rd_err;
  wire own_fault;
  wire setup_phase;
  wire access_done;
  wire timer_busy;
  wire timer_done;
  wire sfail;
  wire line_low;
  wire gate;

  assign own_fault = fault_detect | ctrl_ff[`FSC_CTRL_FORCE];
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign line_low = ~shared_fault_line_in;
  // The serious-failure pin is open drain and only ever pulled low.
  assign serious_failure_flag_oe = sfail;

  fsc_hiccup_timer #(
    .CYCLES(HICCUP_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(timer_start),
    .abort(~device_enable),
    .busy_ff(timer_busy),
    .done_ff(timer_done)
  );

  fsc_fail_detect u_fail (
    .pclk(pclk),
    .presetn(presetn),
    .clear(~device_enable),
    .overcurrent(second_level_overcurrent | negative_overcurrent),
    .phase_on(phase_on),
    .cycle_end(cycle_end),
    .fail_ff(sfail)
  );

  // Fault response sequencing.
  always @*
  begin
    nxt_state = state_ff;
    restart_req = 1'b0;
    timer_start = 1'b0;
    case (state_ff)
      ST_SHUT:
      begin
        if (device_enable)
        begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (converter_enable)
        begin
          nxt_state = ST_RUN;
          restart_req = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (own_fault)
        begin
          if (ctrl_ff[`FSC_CTRL_HICCUP])
          begin
            nxt_state = ST_WAIT;
            timer_start = 1'b1;
          end
          else
          begin
            nxt_state = ST_LATCH;
          end
        end
        else if (!converter_enable)
        begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WAIT:
      begin
        if (timer_done)
        begin
          // A persisting fault sends the block straight back here from run.
          nxt_state = ST_RUN;
          restart_req = 1'b1;
        end
      end
      ST_LATCH:
      begin
        if (!converter_enable)
        begin
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_SHUT;
      end
    endcase
    if (!device_enable)
    begin
      nxt_state = ST_SHUT;
      restart_req = 1'b0;
      timer_start = 1'b0;
    end
  end

  // Status events; a hardware set wins over a read clear in the same cycle.
  always @*
  begin
    hw_set = 6'h00;
    hw_set[`FSC_ST_FAULT] = own_fault & ~fault_prev_ff;
    hw_set[`FSC_ST_WARN] = warning_detect & ~warn_prev_ff;
    hw_set[`FSC_ST_SFAIL] = sfail & ~sfail_prev_ff;
    hw_set[`FSC_ST_LINE] = line_low & ~line_prev_ff;
    hw_set[`FSC_ST_RESTART] = restart_req;
    hw_set[`FSC_ST_CLEARED] = ~own_fault & fault_prev_ff;
    rd_clear = 6'h00;
    if (access_done && !pwrite && paddr == `FSC_OFF_STATUS)
    begin
      // Only the bits the host was shown are cleared.
      rd_clear = prdata[5:0];
    end
    nxt_status = (status_ff & ~rd_clear) | hw_set;
    if (!device_enable)
    begin
      nxt_status = `FSC_STATUS_RST;
    end
  end

  // Read data chosen during the setup phase.
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `FSC_OFF_CTRL:
      begin
        rd_mux[1:0] = ctrl_ff;
      end
      `FSC_OFF_STATUS:
      begin
        rd_mux[5:0] = status_ff;
      end
      `FSC_OFF_MASK:
      begin
        rd_mux[5:0] = mask_ff;
      end
      `FSC_OFF_PINS:
      begin
        rd_mux[`FSC_PIN_LINE] = shared_fault_line_in;
        rd_mux[`FSC_PIN_DIR] = direction_select;
        rd_mux[`FSC_PIN_EN] = device_enable;
        rd_mux[`FSC_PIN_CONV] = converter_enable;
        rd_mux[`FSC_PIN_LATCH] = (state_ff == ST_LATCH);
        rd_mux[`FSC_PIN_WAIT] = timer_busy;
        rd_mux[`FSC_PIN_SFAIL] = ~serious_failure_flag_in;
      end
      default:
      begin
        rd_err = 1'b1;
      end
    endcase
  end

  // APB slave with no wait states; status flag pin level is not read.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl_ff <= `FSC_CTRL_RST;
      mask_ff <= `FSC_MASK_RST;
    end
    else
    begin
      if (setup_phase)
      begin
        pready <= 1'b1;
        pslverr <= rd_err;
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
      else if (access_done)
      begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        if (pwrite && paddr == `FSC_OFF_CTRL)
        begin
          ctrl_ff <= pwdata[1:0];
        end
        if (pwrite && paddr == `FSC_OFF_MASK)
        begin
          mask_ff <= pwdata[5:0];
        end
      end
    end
  end

  assign gate = line_low | shared_fault_line_oe | (state_ff != ST_RUN);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_SHUT;
      status_ff <= `FSC_STATUS_RST;
      fault_prev_ff <= 1'b0;
      warn_prev_ff <= 1'b0;
      line_prev_ff <= 1'b0;
      sfail_prev_ff <= 1'b0;
      irq <= 1'b0;
      shared_fault_line_out <= 1'b0;
      shared_fault_line_oe <= 1'b0;
      status_change_flag_out <= 1'b0;
      status_change_flag_oe <= 1'b0;
      serious_failure_flag_out <= 1'b0;
      pwm_out <= 6'h00;
      driver_enable_out <= 1'b0;
      boost_mode <= 1'b0;
      soft_start_restart <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      status_ff <= nxt_status;
      fault_prev_ff <= own_fault & device_enable;
      warn_prev_ff <= warning_detect & device_enable;
      line_prev_ff <= line_low & device_enable;
      sfail_prev_ff <= sfail;
      irq <= |(nxt_status & mask_ff);
      shared_fault_line_out <= 1'b0;
      shared_fault_line_oe <= (nxt_state == ST_WAIT) | (nxt_state == ST_LATCH);
      status_change_flag_out <= 1'b0;
      status_change_flag_oe <= |nxt_status;
      serious_failure_flag_out <= 1'b0;
      pwm_out <= gate ? 6'h00 : pwm_in;
      driver_enable_out <= ~gate & driver_enable_req;
      boost_mode <= direction_select;
      soft_start_restart <= restart_req;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/fault_signaling_control_tb.sv ====
// Self-checking bench for the fault signalling top.
`default_nettype none
`include "fsc_regs.vh"
module fault_signaling_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HC = 20;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  logic device_enable = 1'h1, converter_enable = 1'h0, direction_select = 1'h0;
  logic fault_detect = 1'h0, warning_detect = 1'h0, second_level_overcurrent = 1'h0;
  logic negative_overcurrent = 1'h0;
  logic phase_on = 1'h0, cycle_end = 1'h0, peer_req = 1'h0, err_q;
  wire logic [31:0] prdata;
  wire logic [5:0] pwm_out;
  wire logic pready, pslverr, irq, shared_fault_line_out, shared_fault_line_oe, peer_oe;
  wire logic status_change_flag_out, status_change_flag_oe, serious_failure_flag_out;
  wire logic serious_failure_flag_oe, driver_enable_out, boost_mode, soft_start_restart;
  wire logic shared_fault_line_in = ~(shared_fault_line_oe | peer_oe);
  wire logic status_change_flag_in = ~status_change_flag_oe;
  wire logic serious_failure_flag_in = ~serious_failure_flag_oe;
  wire logic [31:0] outs = {25'h0, driver_enable_out, pwm_out};
  int err_total = 0, check_count = 0;
  fsc_top #(.HICCUP_CYCLES(HC)) dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .irq, .device_enable, .converter_enable,
    .direction_select, .fault_detect, .warning_detect, .second_level_overcurrent,
    .negative_overcurrent, .phase_on, .cycle_end, .pwm_in(6'h2A),
    .driver_enable_req(1'h1), .shared_fault_line_in, .shared_fault_line_out,
    .shared_fault_line_oe, .status_change_flag_in, .status_change_flag_out,
    .status_change_flag_oe, .serious_failure_flag_in, .serious_failure_flag_out,
    .serious_failure_flag_oe, .pwm_out, .driver_enable_out, .boost_mode,
    .soft_start_restart);
  fsc_peer peer_u (.pclk, .pull_req(peer_req), .pull_oe(peer_oe));
  initial forever #2.5 pclk = ~pclk;
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    check_count++;
    if (got !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'h1);
    q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic wait_ss(output int n);
    n = 0;
    while (soft_start_restart !== 1'h1 && n < 4 * HC)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    int n;
    tick(3);
    presetn <= 1'h1;
    rd(`FSC_OFF_CTRL, 32'h1, "ctrl_rst");
    rd(`FSC_OFF_MASK, 32'h0, "mask_rst");
    rd(`FSC_OFF_STATUS, 32'h0, "status_rst");
    rd(8'h10, 32'h0, "unmapped");
    chk("slverr", 32'h1, err_q);
    converter_enable <= 1'h1;
    direction_select <= 1'h1;
    tick(3);
    chk("boost", 32'h1, boost_mode);
    chk("run", 32'h6A, outs);
    rd(`FSC_OFF_STATUS, 32'h10, "restart_bit");
    apb(1'h1, `FSC_OFF_MASK, 32'h3D);
    warning_detect <= 1'h1;
    tick(2);
    chk("flag_warn", 32'h0, status_change_flag_in);
    chk("irq_masked", 32'h0, irq);
    apb(1'h1, `FSC_OFF_MASK, 32'h3F);
    tick(2);
    chk("irq_warn", 32'h1, irq);
    rd(`FSC_OFF_STATUS, 32'h02, "warn_bit");
    tick(1);
    chk("flag_rel", 32'h1, status_change_flag_in);
    chk("irq_rel", 32'h0, irq);
    peer_req <= 1'h1;
    tick(3);
    chk("peer_gate", 32'h0, outs);
    chk("own_oe", 32'h0, shared_fault_line_oe);
    peer_req <= 1'h0;
    tick(3);
    chk("peer_back", 32'h6A, outs);
    rd(`FSC_OFF_STATUS, 32'h08, "line_bit");
    fault_detect <= 1'h1;
    tick(3);
    chk("wait_gate", 32'h0, outs);
    wait_ss(n);
    chk("gap", 32'h1, n >= HC && n <= HC + 2);
    tick(3);
    chk("retry", 32'h1, shared_fault_line_oe);
    fault_detect <= 1'h0;
    wait_ss(n);
    tick(3);
    chk("stop", 32'h0, shared_fault_line_oe);
    rd(`FSC_OFF_STATUS, 32'h39, "hiccup_bits");
    apb(1'h1, `FSC_OFF_CTRL, 32'h2);
    apb(1'h1, `FSC_OFF_CTRL, 32'h0);
    tick(3 * HC);
    chk("latched", 32'h1, shared_fault_line_oe);
    chk("od_data", 32'h0, {29'h0, shared_fault_line_out, status_change_flag_out,
      serious_failure_flag_out});
    converter_enable <= 1'h0;
    tick(2);
    chk("latch_rel", 32'h0, shared_fault_line_oe);
    converter_enable <= 1'h1;
    tick(3);
    chk("restart", 32'h6A, outs);
    for (int i = 0; i < 6; i++)
    begin
      second_level_overcurrent <= i < 2;
      negative_overcurrent <= i > 2;
      phase_on <= 1'h1;
      tick(2);
      phase_on <= 1'h0;
      tick(1);
      cycle_end <= 1'h1;
      tick(1);
      cycle_end <= 1'h0;
      tick(3);
      chk("sfail", {31'h0, i == 5}, {31'h0, ~serious_failure_flag_in});
    end
    second_level_overcurrent <= 1'h0;
    negative_overcurrent <= 1'h0;
    apb(1'h0, `FSC_OFF_PINS, 32'h0);
    chk("pins_sfail", 32'h1, q[6]);
    chk("kept", 32'h1, irq);
    device_enable <= 1'h0;
    tick(2);
    chk("sfail_clr", 32'h1, serious_failure_flag_in);
    rd(`FSC_OFF_STATUS, 32'h0, "status_clr");
    complete_run();
  end
  initial
  begin
    tick(3000);
    chk("watchdog", 32'h0, 32'h1);
    complete_run();
  end
endmodule
bind fsc_top fsc_props #(.HICCUP_CYCLES(HICCUP_CYCLES)) props_u (.pclk, .presetn,
  .device_enable, .converter_enable, .direction_select, .warning_detect,
  .shared_fault_line_in, .shared_fault_line_oe, .status_change_flag_oe,
  .serious_failure_flag_oe, .irq, .pwm_out, .driver_enable_out, .boost_mode,
  .soft_start_restart);
`default_nettype wire

// ==== testbench/fsc_peer.sv ====
// Behavioural peer controller that pulls the shared fault line low on request.
`default_nettype none
module fsc_peer (
  input wire logic pclk,
  input wire logic pull_req,
  output logic pull_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pull_oe = 1'h0;
  always @(posedge pclk)
    pull_oe <= pull_req;
endmodule
`default_nettype wire

// ==== testbench/fsc_props.sv ====
// Concurrent checks on the fault signalling top ports.
`default_nettype none
module fsc_props #(
  parameter [31:0] HICCUP_CYCLES = 32'h14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic device_enable,
  input wire logic converter_enable,
  input wire logic direction_select,
  input wire logic warning_detect,
  input wire logic shared_fault_line_in,
  input wire logic shared_fault_line_oe,
  input wire logic status_change_flag_oe,
  input wire logic serious_failure_flag_oe,
  input wire logic irq,
  input wire logic [5:0] pwm_out,
  input wire logic driver_enable_out,
  input wire logic boost_mode,
  input wire logic soft_start_restart
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] gap_ff;
  // Counts how long the line has been pulled by this device.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      gap_ff <= 32'h0;
    else if (shared_fault_line_oe)
      gap_ff <= gap_ff + 32'h1;
    else
      gap_ff <= 32'h0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence restart_s;
    $fell(shared_fault_line_oe) ##0 soft_start_restart;
  endsequence
  line_gate_a: assert property (
    !shared_fault_line_in |=> pwm_out == 6'h00 && !driver_enable_out)
    else $error("outputs live while line low");
  dir_follow_a: assert property (
    1'h1 |=> boost_mode == $past(direction_select))
    else $error("direction not followed");
  warn_flag_a: assert property (
    $rose(warning_detect) && device_enable |=> status_change_flag_oe)
    else $error("warning did not raise flag");
  line_flag_a: assert property (
    $fell(shared_fault_line_in) && device_enable |=> status_change_flag_oe)
    else $error("line fall did not raise flag");
  irq_flag_a: assert property (
    irq |-> status_change_flag_oe)
    else $error("irq without pending status");
  en_clear_a: assert property (
    !device_enable |=> !status_change_flag_oe && !irq && !serious_failure_flag_oe)
    else $error("shutdown did not clear status");
  sfail_hold_a: assert property (
    serious_failure_flag_oe && device_enable |=> serious_failure_flag_oe)
    else $error("failure flag dropped");
  restart_pulse_a: assert property (
    $fell(shared_fault_line_oe) && $past(converter_enable) && $past(device_enable)
    |-> soft_start_restart)
    else $error("hiccup release without restart");
  hiccup_gap_a: assert property (
    restart_s |-> gap_ff >= HICCUP_CYCLES && gap_ff <= HICCUP_CYCLES + 32'h2)
    else $error("hiccup interval wrong");
endmodule
`default_nettype wire
